// ### rtl/dcm_clock_mode_divider.sv
// Clock mode selection, cpu and system clock dividers, clock output pin
// Function
// R1: Mode 00 direct div2, 01 direct div1, 10 PLL div2, 11 PLL div1; once locked, both PLL modes pass the PLL clock undivided.
// R2: Cpu clock period is two or one input periods, also before lock.
// R3: System clock is cpu clock over two or four; reset forces four.
// R4: Clock output pin shows the cpu clock after power-on reset.
// R5: Fully static logic; nothing changes while the input clock stands. In a locked PLL mode the cpu clock still follows pll_clock.
// R6: All clock outputs launched together from the same internal edge.
`timescale 1ns/1ps
module dcm_clock_mode_divider (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Clock sources
  input wire logic input_clock_pin,
  input wire logic pll_clock,
  input wire logic pll_locked,
  // Mode selection
  input wire logic [1:0] clock_mode_select,
  // System clock divider control
  input wire logic sys_div_load,
  input wire logic sys_div_value,
  // Clock output pin source control
  input wire logic pin_src_load,
  input wire logic pin_src_value,
  // Generated clocks, pll enable and setting readback
  output dcm_pkg::dcm_clocks_type clocks,
  output logic pll_enable,
  output logic sys_div_sel,
  output logic pin_src_sel
);
  import dcm_pkg::*;

  logic in_prev_reg;
  logic cnt_reg;
  logic cnt_next;
  logic sys_div_sel_reg;
  logic pin_src_reg;
  logic pll_enable_reg;
  dcm_clocks_type clocks_reg;
  dcm_clocks_type clocks_next;
  logic in_rise;
  logic in_fall;
  logic use_pll_clk;
  logic div1_mode;
  logic cpu_rise;

  assign in_rise = input_clock_pin & ~in_prev_reg;
  assign in_fall = ~input_clock_pin & in_prev_reg;
  // Before lock the PLL modes run from the input like the direct modes
  assign use_pll_clk = clock_mode_select[DCM_MODE_PLL_BIT] & pll_locked; // [R1]
  assign div1_mode = clock_mode_select[DCM_MODE_DIV1_BIT]; // [R1]

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      in_prev_reg <= DCM_CLK_RESET;
    end else begin
      in_prev_reg <= input_clock_pin;
    end
  end

  // Setting registers; reset covers both device and power-on reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sys_div_sel_reg <= DCM_SYS_DIV_RESET; // [R3]
    end else if (sys_div_load) begin
      sys_div_sel_reg <= sys_div_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_src_reg <= DCM_PIN_SRC_RESET; // [R4]
    end else if (pin_src_load) begin
      pin_src_reg <= pin_src_value;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pll_enable_reg <= 1'h0;
    end else begin
      pll_enable_reg <= clock_mode_select[DCM_MODE_PLL_BIT]; // [R1]
    end
  end

  // All clocks computed together so they leave from one edge
  always_comb begin
    clocks_next = clocks_reg;
    cnt_next = cnt_reg;
    if (use_pll_clk) begin
      clocks_next.cpu_clock = pll_clock;
    end else if (div1_mode) begin
      clocks_next.cpu_clock = input_clock_pin; // [R2]
    end else if (in_rise) begin
      clocks_next.cpu_clock = ~clocks_reg.cpu_clock; // [R2]
    end
    // Kept inside this process so the divider sees no combinational loop
    cpu_rise = clocks_next.cpu_clock & ~clocks_reg.cpu_clock;
    // Divider advances only on cpu edges, so a stopped input freezes it except in a locked PLL mode
    if (cpu_rise) begin // [R5]
      if (sys_div_sel_reg == DCM_SYS_DIV2) begin
        clocks_next.system_clock = ~clocks_reg.system_clock; // [R3]
        cnt_next = DCM_SYS_CNT_RESET;
      end else if (cnt_reg == DCM_SYS_DIV4_LAST) begin
        clocks_next.system_clock = ~clocks_reg.system_clock; // [R3]
        cnt_next = DCM_SYS_CNT_RESET;
      end else begin
        cnt_next = ~cnt_reg;
      end
    end
    if (pin_src_reg == DCM_PIN_SRC_CPU) begin
      clocks_next.clock_output_pin = clocks_next.cpu_clock; // [R6]
    end else begin
      clocks_next.clock_output_pin = clocks_next.system_clock; // [R6]
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      clocks_reg <= DCM_CLOCKS_RESET;
      cnt_reg <= DCM_SYS_CNT_RESET;
    end else begin
      clocks_reg <= clocks_next; // [R6]
      cnt_reg <= cnt_next;
    end
  end

  assign clocks = clocks_reg;
  assign pll_enable = pll_enable_reg;
  assign sys_div_sel = sys_div_sel_reg;
  assign pin_src_sel = pin_src_reg;

  property p_div2_toggle;
    @(posedge clk) disable iff (!reset_n)
    (!use_pll_clk && !div1_mode && in_rise) |=>
      clocks_reg.cpu_clock != $past(clocks_reg.cpu_clock);
  endproperty
  a_div2_toggle: assert property (p_div2_toggle) // [R2]
    else $error("cpu clock missed toggle on input rise");

  property p_div1_follow;
    @(posedge clk) disable iff (!reset_n)
    (!use_pll_clk && div1_mode) |=>
      clocks_reg.cpu_clock == $past(input_clock_pin);
  endproperty
  a_div1_follow: assert property (p_div1_follow) // [R1]
    else $error("cpu clock does not follow input in div1");

  property p_pll_follow;
    @(posedge clk) disable iff (!reset_n)
    use_pll_clk |=> clocks_reg.cpu_clock == $past(pll_clock);
  endproperty
  a_pll_follow: assert property (p_pll_follow) // [R1]
    else $error("cpu clock does not follow locked pll");

  property p_static;
    @(posedge clk) disable iff (!reset_n)
    (!use_pll_clk && !in_rise && !in_fall && !sys_div_load &&
      !pin_src_load && $stable(clock_mode_select) &&
      $stable(pin_src_reg) && $stable(use_pll_clk)) |=> $stable(clocks_reg);
  endproperty
  a_static: assert property (p_static) // [R5]
    else $error("clocks changed while input clock stood");

  property p_sys_reset;
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> sys_div_sel_reg == DCM_SYS_DIV4;
  endproperty
  a_sys_reset: assert property (p_sys_reset) // [R3]
    else $error("system divider not div4 after reset");

  property p_sys_div4;
    @(posedge clk) disable iff (!reset_n)
    (sys_div_sel_reg == DCM_SYS_DIV4 && cpu_rise &&
      cnt_reg == DCM_SYS_CNT_RESET) |=>
      $stable(clocks_reg.system_clock) && cnt_reg == DCM_SYS_DIV4_LAST;
  endproperty
  a_sys_div4: assert property (p_sys_div4) // [R3]
    else $error("system clock toggled early in div4");

  property p_sys_div4_toggle;
    @(posedge clk) disable iff (!reset_n)
    (sys_div_sel_reg == DCM_SYS_DIV4 && cpu_rise &&
      cnt_reg == DCM_SYS_DIV4_LAST) |=>
      clocks_reg.system_clock != $past(clocks_reg.system_clock) &&
      cnt_reg == DCM_SYS_CNT_RESET;
  endproperty
  a_sys_div4_toggle: assert property (p_sys_div4_toggle) // [R3]
    else $error("system clock missed toggle in div4");

  property p_pll_enable;
    @(posedge clk) disable iff (!reset_n)
    clock_mode_select[DCM_MODE_PLL_BIT] |=> pll_enable_reg;
  endproperty
  a_pll_enable: assert property (p_pll_enable) // [R1]
    else $error("pll not enabled in pll mode");

  property p_sys_div2;
    @(posedge clk) disable iff (!reset_n)
    (sys_div_sel_reg == DCM_SYS_DIV2 && cpu_rise) |=>
      clocks_reg.system_clock != $past(clocks_reg.system_clock);
  endproperty
  a_sys_div2: assert property (p_sys_div2) // [R3]
    else $error("system clock missed toggle in div2");

  property p_pin_reset;
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> pin_src_reg == DCM_PIN_SRC_CPU;
  endproperty
  a_pin_reset: assert property (p_pin_reset) // [R4]
    else $error("clock pin source not cpu after reset");

  property p_pin_same_edge;
    @(posedge clk) disable iff (!reset_n)
    (pin_src_reg == DCM_PIN_SRC_CPU && $stable(pin_src_reg)) |->
      clocks_reg.clock_output_pin == clocks_reg.cpu_clock;
  endproperty
  a_pin_same_edge: assert property (p_pin_same_edge) // [R6]
    else $error("clock pin skewed from cpu clock");

  c_div2: cover property (@(posedge clk) disable iff (!reset_n)
    !use_pll_clk && !div1_mode && in_rise && clocks_reg.cpu_clock);
  c_sys_div4: cover property (@(posedge clk) disable iff (!reset_n)
    (sys_div_sel_reg == DCM_SYS_DIV4) && $rose(clocks_reg.system_clock));
  c_pll: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(use_pll_clk));
  c_pin_sys: cover property (@(posedge clk) disable iff (!reset_n)
    pin_src_reg == DCM_PIN_SRC_SYS && $rose(clocks_reg.clock_output_pin));
endmodule

// ### pkg/dcm_pkg.sv
// Constants and types for the clock mode divider
package dcm_pkg;
  // Clock mode selection codes
  localparam logic [1:0] DCM_MODE_DIRECT_DIV2 = 2'h0;
  localparam logic [1:0] DCM_MODE_DIRECT_DIV1 = 2'h1;
  localparam logic [1:0] DCM_MODE_PLL_DIV2 = 2'h2;
  localparam logic [1:0] DCM_MODE_PLL_DIV1 = 2'h3;
  // Field positions within the mode selection
  localparam int DCM_MODE_DIV1_BIT = 0;
  localparam int DCM_MODE_PLL_BIT = 1;
  // System clock divider settings
  localparam logic DCM_SYS_DIV4 = 1'h0;
  localparam logic DCM_SYS_DIV2 = 1'h1;
  localparam logic DCM_SYS_DIV_RESET = DCM_SYS_DIV4;
  // Cpu clock rises per system clock half period, minus one, in div4
  localparam logic DCM_SYS_DIV4_LAST = 1'h1;
  localparam logic DCM_SYS_CNT_RESET = 1'h0;
  // Clock output pin source
  localparam logic DCM_PIN_SRC_CPU = 1'h0;
  localparam logic DCM_PIN_SRC_SYS = 1'h1;
  localparam logic DCM_PIN_SRC_RESET = DCM_PIN_SRC_CPU;
  // Clock level after reset
  localparam logic DCM_CLK_RESET = 1'h0;

  typedef struct packed {
    logic cpu_clock;
    logic system_clock;
    logic clock_output_pin;
  } dcm_clocks_type;

  localparam dcm_clocks_type DCM_CLOCKS_RESET = '{
    DCM_CLK_RESET, DCM_CLK_RESET, DCM_CLK_RESET};
endpackage

// ### testbench/dcm_osc_model.sv
// Model of the external clock source feeding the block
`timescale 1ns/1ps
module dcm_osc_model (
  // Clock
  input wire logic clk,
  // Source clocks
  output logic input_clock_pin,
  output logic pll_clock
);
  initial begin
    input_clock_pin = 1'h0;
    pll_clock = 1'h0;
  end
  // n input pulses, two pll pulses each; both then stand low
  task automatic burst(input int n);
    for (int i = 0; i < 2 * n; i++) begin
      input_clock_pin = ~input_clock_pin;
      repeat (2) begin
        pll_clock = ~pll_clock;
        repeat (2) @(negedge clk);
      end
    end
  endtask
endmodule

// ### testbench/dcm_clock_mode_divider_test.sv
// Self-checking bench of the clock mode divider
`timescale 1ns/1ps
module dcm_clock_mode_divider_test;
  import dcm_pkg::*;
  logic clk, reset_n, pll_locked, sys_div_load, sys_div_value;
  logic pin_src_load, pin_src_value, pll_enable, sys_div_sel, pin_src_sel;
  logic input_clock_pin, pll_clock;
  logic [1:0] clock_mode_select;
  dcm_clocks_type clocks, clocks_prev;
  logic [7:0] n_cpu = 8'h00, n_sys = 8'h00, n_pin = 8'h00;
  int fails = 0, compares = 0, cycles = 0;
  dcm_osc_model osc (.clk(clk), .input_clock_pin(input_clock_pin),
    .pll_clock(pll_clock));
  dcm_clock_mode_divider DUT (.clk(clk), .reset_n(reset_n),
    .input_clock_pin(input_clock_pin), .pll_clock(pll_clock),
    .pll_locked(pll_locked), .clock_mode_select(clock_mode_select),
    .sys_div_load(sys_div_load), .sys_div_value(sys_div_value),
    .pin_src_load(pin_src_load), .pin_src_value(pin_src_value),
    .clocks(clocks), .pll_enable(pll_enable), .sys_div_sel(sys_div_sel),
    .pin_src_sel(pin_src_sel));
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  // Toggle counts; only differences are used, so no clearing needed
  always @(posedge clk) begin
    clocks_prev <= clocks;
    n_cpu <= n_cpu + 8'(clocks.cpu_clock !== clocks_prev.cpu_clock);
    n_sys <= n_sys + 8'(clocks.system_clock !== clocks_prev.system_clock);
    n_pin <= n_pin + 8'(clocks.clock_output_pin !==
      clocks_prev.clock_output_pin);
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end
  task automatic check(input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_reset();
    reset_n = 1'h0;
    repeat (8) @(negedge clk);
    check(sys_div_sel, DCM_SYS_DIV_RESET);
    check(pin_src_sel, DCM_PIN_SRC_RESET);
    check(clocks, DCM_CLOCKS_RESET);
    reset_n = 1'h1;
  endtask
  task automatic load(input logic sys, input logic val);
    sys_div_load = sys;
    sys_div_value = val;
    pin_src_load = ~sys;
    pin_src_value = val;
    @(negedge clk);
    sys_div_load = 1'h0;
    pin_src_load = 1'h0;
    @(negedge clk);
    check(sys ? sys_div_sel : pin_src_sel, val);
  endtask
  // Burst of 8 input pulses, then the source stands still
  task automatic run(input logic [1:0] mode, input logic lock,
      input logic [7:0] e_cpu, e_sys, e_pin);
    logic [7:0] c0, s0, p0;
    clock_mode_select = mode;
    pll_locked = lock;
    repeat (4) @(negedge clk);
    check(pll_enable, mode[DCM_MODE_PLL_BIT]);
    c0 = n_cpu;
    s0 = n_sys;
    p0 = n_pin;
    osc.burst(8);
    repeat (6) @(negedge clk);
    check(n_cpu - c0, e_cpu);
    check(n_sys - s0, e_sys);
    check(n_pin - p0, e_pin);
    c0 = n_cpu + n_sys + n_pin;
    repeat (30) @(negedge clk);
    check(n_cpu + n_sys + n_pin - c0, 8'h00);
  endtask
  initial begin
    {reset_n, pll_locked, sys_div_load, sys_div_value} = 4'h0;
    {pin_src_load, pin_src_value} = 2'h0;
    clock_mode_select = DCM_MODE_DIRECT_DIV2;
    @(negedge clk);
    do_reset();
    run(DCM_MODE_DIRECT_DIV2, 1'h0, 8'h08, 8'h02, 8'h08);
    run(DCM_MODE_DIRECT_DIV1, 1'h0, 8'h10, 8'h04, 8'h10);
    load(1'h1, DCM_SYS_DIV2);
    run(DCM_MODE_PLL_DIV2, 1'h0, 8'h08, 8'h04, 8'h08);
    run(DCM_MODE_PLL_DIV1, 1'h0, 8'h10, 8'h08, 8'h10);
    run(DCM_MODE_PLL_DIV2, 1'h1, 8'h20, 8'h10, 8'h20);
    load(1'h0, DCM_PIN_SRC_SYS);
    run(DCM_MODE_DIRECT_DIV2, 1'h0, 8'h08, 8'h04, 8'h04);
    // Reset in mid-run must bring back div4 and the cpu pin source
    do_reset();
    run(DCM_MODE_DIRECT_DIV1, 1'h0, 8'h10, 8'h04, 8'h10);
    print_verdict();
  end
endmodule
